// *** pkg/edid_pkg.sv ***
package edid_pkg;
  // Array sizes
  localparam int NUM_IN        = 4;
  localparam int NUM_OUT       = 2;
  localparam int LIB_SLOTS     = 8;
  localparam int FACTORY_SLOTS = 4;
  localparam int IN_W          = 2;
  localparam int OUT_W         = 1;
  localparam int SLOT_W        = 3;
  localparam int IMAGE_BYTES   = 256;

  // Byte offsets inside an image, and the good checksum sum
  localparam logic [7:0] FIRST_ADDR      = 8'h00;
  localparam logic [7:0] LAST_ADDR       = 8'hFF;
  localparam logic [7:0] BASE_LAST_ADDR  = 8'h7F;
  localparam logic [7:0] EXT_COUNT_ADDR  = 8'h7E;
  localparam logic [7:0] EXT_FIRST_ADDR  = 8'h80;
  localparam logic [7:0] SUM_OK          = 8'h00;

  // Vendor block marker looked for in the extension
  localparam logic [23:0] HDMI_OUI_SEQ   = 24'h030C00;

  // Hot-plug low time
  localparam int CLK_MHZ        = 250;
  localparam int HPD_LOW_MS     = 2000;
  localparam int HPD_LOW_CYCLES = HPD_LOW_MS * CLK_MHZ * 1000;
  localparam int HPD_CNT_W      = 29;

  // Copy engine cycles from start to done
  localparam int COPY_CYCLES = IMAGE_BYTES + 2;

  typedef enum logic [1:0] {CP_IDLE, CP_RUN, CP_DRAIN} copy_state_t;
endpackage

// *** pkg/edid_copy_if.sv ***
`timescale 1ns/1ns
interface edid_copy_if;
  logic       start;
  logic       busy;
  logic       done;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  modport eng (input start, rd_data,
               output busy, done, rd_addr, wr_en, wr_addr, wr_data);
  modport ctl (output start, rd_data,
               input busy, done, rd_addr, wr_en, wr_addr, wr_data);
endinterface

// *** design/edid_copier.sv ***
`timescale 1ns/1ns
module edid_copier (
  input wire logic clock, // System clock
  input wire logic reset, // Synchronous, active high
  edid_copy_if.eng cp     // Copy request and memory ports
);
  typedef struct packed {
    edid_pkg::copy_state_t state;
    logic [7:0]            addr;
    logic                  wr_en;
    logic [7:0]            wr_addr;
    logic                  done;
  } copier_state_t;

  copier_state_t s;
  copier_state_t next_s;

  // Walk all bytes of an image, write one cycle behind the read
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.state)
      edid_pkg::CP_IDLE: begin
        next_s.wr_en = 1'b0;
        if (cp.start) begin
          next_s.state = edid_pkg::CP_RUN;
          next_s.addr  = edid_pkg::FIRST_ADDR;
        end
      end
      edid_pkg::CP_RUN: begin
        next_s.wr_en   = 1'b1;
        next_s.wr_addr = s.addr;
        next_s.addr    = s.addr + 8'h01;
        if (s.addr == edid_pkg::LAST_ADDR) begin
          next_s.state = edid_pkg::CP_DRAIN;
        end
      end
      default: begin
        next_s.wr_en = 1'b0;
        next_s.done  = 1'b1;
        next_s.state = edid_pkg::CP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Memory side drive
  assign cp.rd_addr = s.addr;
  assign cp.wr_en   = s.wr_en;
  assign cp.wr_addr = s.wr_addr;
  assign cp.wr_data = cp.rd_data;
  assign cp.done    = s.done;
  assign cp.busy    = (s.state != edid_pkg::CP_IDLE);

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // Full image copied in fixed time
  a_copy_length: assert property (
    (cp.start && s.state == edid_pkg::CP_IDLE) |-> ##258 cp.done)
    else $error("copy did not finish in 258 cycles");
endmodule

// *** design/hpd_pulse.sv ***
`timescale 1ns/1ns
module hpd_pulse #(
  parameter int HOLD = edid_pkg::HPD_LOW_CYCLES // Low time in cycles
) (
  input  wire logic clock, // System clock
  input  wire logic reset, // Synchronous, active high
  input  wire logic start, // One-cycle request for a low pulse
  output logic      hpd    // Hot-plug level, high when present
);
  localparam logic [edid_pkg::HPD_CNT_W-1:0] HOLD_LAST =
    edid_pkg::HPD_CNT_W'(HOLD - 1);

  typedef struct packed {
    logic                            low;
    logic                            level;
    logic [edid_pkg::HPD_CNT_W-1:0]  cnt;
  } hpd_state_t;

  hpd_state_t s;
  hpd_state_t next_s;

  // Drop the line for the hold time, restart on a new request
  always_comb begin
    next_s = s;
    if (start) begin
      next_s.low = 1'b1;
      next_s.cnt = HOLD_LAST;
    end else if (s.low) begin
      if (s.cnt == '0) begin
        next_s.low = 1'b0;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
    next_s.level = !next_s.low;
  end

  // State register, line high out of reset
  always_ff @(posedge clock) begin
    if (reset) begin
      s       <= '0;
      s.level <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hpd = s.level;

  // Cycles low since the last request
  int since;
  always_ff @(posedge clock) begin
    if (reset || start) begin
      since <= 0;
    end else if (!hpd) begin
      since <= since + 1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_hpd_drop: assert property (start |=> !hpd)
    else $error("hot-plug did not drop after request");
  a_hpd_length: assert property ($rose(hpd) |-> since == HOLD)
    else $error("hot-plug low time wrong");
  c_hpd_pulse: cover property ($rose(hpd));
endmodule

// *** design/edid_router.sv ***
`timescale 1ns/1ns
module edid_router #(
  parameter int HPD_HOLD_CYCLES = edid_pkg::HPD_LOW_CYCLES // Hot-plug low
) (
  input  wire logic                          CLOCK,          // 250 MHz
  input  wire logic                          RESET,          // Sync reset
  input  wire logic                          LIB_WR,         // Library write
  input  wire logic [edid_pkg::SLOT_W-1:0]   LIB_SLOT,       // Library slot
  input  wire logic [7:0]                    LIB_ADDR,       // Byte address
  input  wire logic [7:0]                    LIB_DATA,       // Byte value
  input  wire logic                          FACTORY_UNLOCK, // Preset write
  input  wire logic                          CAP_WR,         // Sink byte
  input  wire logic [edid_pkg::OUT_W-1:0]    CAP_PORT,       // Output index
  input  wire logic [7:0]                    CAP_ADDR,       // Byte address
  input  wire logic [7:0]                    CAP_DATA,       // Byte value
  input  wire logic                          CAP_DONE,       // Sink read end
  input  wire logic                          SEL_GO,         // Assign pulse
  input  wire logic [edid_pkg::IN_W-1:0]     SEL_IN,         // Target input
  input  wire logic                          SEL_DYNAMIC,    // 1 = dynamic
  input  wire logic [edid_pkg::SLOT_W-1:0]   SEL_SLOT,       // Static slot
  input  wire logic [edid_pkg::OUT_W-1:0]    SEL_OUT,        // Dynamic out
  input  wire logic [edid_pkg::NUM_IN-1:0][7:0] SRC_ADDR,    // Source reads
  output logic      [edid_pkg::NUM_IN-1:0][7:0] SRC_DATA,    // Read data
  output logic      [edid_pkg::NUM_IN-1:0]   HPD,            // Hot-plug
  output logic      [edid_pkg::NUM_IN-1:0]   HDMI_CAP,       // HDMI image
  output logic      [edid_pkg::NUM_OUT-1:0]  CAP_VALID,      // Sink stored
  output logic                               BUSY            // Copy running
);
  localparam int NI = edid_pkg::NUM_IN;
  localparam int NO = edid_pkg::NUM_OUT;
  localparam int IB = edid_pkg::IMAGE_BYTES;

  typedef struct packed {
    logic [NI-1:0]                         bank;
    logic [NI-1:0]                         dyn;
    logic [NI-1:0][edid_pkg::SLOT_W-1:0]   slot;
    logic [NI-1:0][edid_pkg::OUT_W-1:0]    outsel;
    logic [NI-1:0]                         pending;
    logic                                  busy;
    logic                                  start;
    logic [edid_pkg::IN_W-1:0]             cur_in;
    logic                                  cur_dyn;
    logic [edid_pkg::SLOT_W-1:0]           cur_slot;
    logic [edid_pkg::OUT_W-1:0]            cur_out;
    logic                                  cur_bank;
    logic [NO-1:0]                         cap_bank;
    logic [NO-1:0]                         cap_valid;
    logic [NO-1:0]                         cap_full;
    logic [NO-1:0][7:0]                    cap_sum;
    logic [NI-1:0]                         hpd_go;
    logic [NI-1:0]                         hdmi;
    logic                                  ext_seen;
    logic                                  oui;
    logic [23:0]                           tail;
  } router_state_t;

  router_state_t s;
  router_state_t next_s;
  logic          commit;
  logic [7:0]    rd_q;

  // Image stores
  logic [7:0] lib_mem [edid_pkg::LIB_SLOTS*IB];
  logic [7:0] cap_mem [NO*2*IB];
  logic [7:0] emu_mem [NI*2*IB];

  edid_copy_if cp ();

  edid_copier u_copier (
    .clock (CLOCK),
    .reset (RESET),
    .cp    (cp.eng)
  );

  // Capture accepted only with a full base block and good checksum
  assign commit = CAP_DONE && s.cap_full[CAP_PORT] &&
                  (s.cap_sum[CAP_PORT] == edid_pkg::SUM_OK);

  // Control, dispatch and capture bookkeeping
  always_comb begin
    next_s = s;
    next_s.start  = 1'b0;
    next_s.hpd_go = '0;
    // Assignment of any source to any input
    if (SEL_GO) begin
      next_s.dyn[SEL_IN]    = SEL_DYNAMIC;
      next_s.slot[SEL_IN]   = SEL_SLOT;
      next_s.outsel[SEL_IN] = SEL_OUT;
    end
    // Running checksum of the incoming sink image
    if (CAP_WR) begin
      if (CAP_ADDR == edid_pkg::FIRST_ADDR) begin
        next_s.cap_sum[CAP_PORT]  = CAP_DATA;
        next_s.cap_full[CAP_PORT] = 1'b0;
      end else begin
        next_s.cap_sum[CAP_PORT] = s.cap_sum[CAP_PORT] + CAP_DATA;
      end
      if (CAP_ADDR == edid_pkg::BASE_LAST_ADDR) begin
        next_s.cap_full[CAP_PORT] = 1'b1;
      end
    end
    // New capture becomes the kept image of that output
    if (commit) begin
      next_s.cap_bank[CAP_PORT]  = !s.cap_bank[CAP_PORT];
      next_s.cap_valid[CAP_PORT] = 1'b1;
      next_s.cap_full[CAP_PORT]  = 1'b0;
    end
    // Start one copy, lowest pending input first
    if (!s.busy) begin
      for (int i = NI - 1; i >= 0; i--) begin
        if (s.pending[i]) begin
          next_s.busy       = 1'b1;
          next_s.start      = 1'b1;
          next_s.cur_in     = edid_pkg::IN_W'(i);
          next_s.cur_dyn    = s.dyn[i];
          next_s.cur_slot   = s.slot[i];
          next_s.cur_out    = s.outsel[i];
          next_s.cur_bank   = s.cap_bank[s.outsel[i]];
          next_s.ext_seen   = 1'b0;
          next_s.oui        = 1'b0;
          next_s.tail       = '0;
        end
      end
      // Only the chosen input leaves the queue, the rest wait their turn
      if (next_s.start) begin
        next_s.pending[next_s.cur_in] = 1'b0;
      end
    end
    // Watch the image as it is written
    if (cp.wr_en) begin
      if (cp.wr_addr == edid_pkg::EXT_COUNT_ADDR) begin
        next_s.ext_seen = (cp.wr_data != 8'h00);
      end
      if (cp.wr_addr >= edid_pkg::EXT_FIRST_ADDR) begin
        next_s.tail = {s.tail[15:0], cp.wr_data};
      end
    end
    if (s.tail == edid_pkg::HDMI_OUI_SEQ) begin
      next_s.oui = 1'b1;
    end
    // Swap in the finished image, then pulse hot-plug
    if (cp.done) begin
      next_s.bank[s.cur_in]   = !s.bank[s.cur_in];
      next_s.hpd_go[s.cur_in] = 1'b1;
      next_s.hdmi[s.cur_in]   = s.ext_seen &&
        (s.oui || s.tail == edid_pkg::HDMI_OUI_SEQ);
      next_s.busy = 1'b0;
    end
    // Requests last, so a new one beats the dispatch clear
    for (int i = 0; i < NI; i++) begin
      if (SEL_GO && SEL_IN == edid_pkg::IN_W'(i) &&
          !(SEL_DYNAMIC && !s.cap_valid[SEL_OUT])) begin
        next_s.pending[i] = 1'b1;
      end
      if (commit && s.dyn[i] && s.outsel[i] == CAP_PORT) begin
        next_s.pending[i] = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Library writes, presets guarded
  always_ff @(posedge CLOCK) begin
    if (LIB_WR && (LIB_SLOT >= edid_pkg::SLOT_W'(edid_pkg::FACTORY_SLOTS)
                   || FACTORY_UNLOCK)) begin
      lib_mem[{LIB_SLOT, LIB_ADDR}] <= LIB_DATA;
    end
  end

  // Sink bytes go to the spare bank of their output
  always_ff @(posedge CLOCK) begin
    if (CAP_WR) begin
      cap_mem[{CAP_PORT, !s.cap_bank[CAP_PORT], CAP_ADDR}] <= CAP_DATA;
    end
  end

  // Copy source read, library or captured image
  always_ff @(posedge CLOCK) begin
    if (s.cur_dyn) begin
      rd_q <= cap_mem[{s.cur_out, s.cur_bank, cp.rd_addr}];
    end else begin
      rd_q <= lib_mem[{s.cur_slot, cp.rd_addr}];
    end
  end

  // New image lands in the bank the source is not reading
  always_ff @(posedge CLOCK) begin
    if (cp.wr_en) begin
      emu_mem[{s.cur_in, !s.bank[s.cur_in], cp.wr_addr}] <= cp.wr_data;
    end
  end

  assign cp.start   = s.start;
  assign cp.rd_data = rd_q;

  // One read port and one hot-plug line per input
  for (genvar g = 0; g < NI; g++) begin : g_input
    always_ff @(posedge CLOCK) begin
      if (RESET) begin
        SRC_DATA[g] <= 8'h00;
      end else begin
        SRC_DATA[g] <= emu_mem[{edid_pkg::IN_W'(g), s.bank[g],
                                SRC_ADDR[g]}];
      end
    end
    hpd_pulse #(
      .HOLD (HPD_HOLD_CYCLES)
    ) u_hpd (
      .clock (CLOCK),
      .reset (RESET),
      .start (s.hpd_go[g]),
      .hpd   (HPD[g])
    );
  end

  // Status straight from the state register
  assign HDMI_CAP  = s.hdmi;
  assign CAP_VALID = s.cap_valid;
  assign BUSY      = s.busy;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_swap_then_pulse: assert property (
    cp.done |=> (s.hpd_go != '0) && (s.bank != $past(s.bank)))
    else $error("no bank swap and hot-plug after copy");
  a_old_image_held: assert property (
    (s.busy && !cp.done) |=> s.bank == $past(s.bank))
    else $error("bank swapped before copy end");
  a_one_input_only: assert property (
    cp.done |=> $countones(s.bank ^ $past(s.bank)) == 1)
    else $error("more than one input changed");
  a_hdmi_needs_ext: assert property (
    (cp.done && !s.ext_seen) |=> !s.hdmi[$past(s.cur_in)])
    else $error("HDMI shown without extension");
  a_static_ignores: assert property (
    (CAP_DONE && !SEL_GO && !s.dyn[0] && !s.pending[0]) |=> !s.pending[0])
    else $error("static input reacted to sink");
  a_dyn_follows: assert property (
    (commit && s.dyn[0] && s.outsel[0] == CAP_PORT) |=> s.pending[0])
    else $error("dynamic input missed new capture");
  a_bad_cap_dropped: assert property (
    (CAP_DONE && !commit) |=> s.cap_bank == $past(s.cap_bank))
    else $error("invalid capture replaced stored image");
  a_cap_kept: assert property (s.cap_valid[0] |=> s.cap_valid[0])
    else $error("captured image lost");
  a_copy_bounded: assert property (s.start |-> ##[1:300] cp.done)
    else $error("copy did not complete");
  a_write_in_copy: assert property (cp.wr_en |-> s.busy)
    else $error("image write outside a copy");
  a_engine_in_copy: assert property (cp.busy |-> s.busy)
    else $error("copy engine ran outside a copy");

  c_static_copy: cover property (s.start && !s.cur_dyn ##[1:300] cp.done);
  c_dyn_update: cover property (commit && s.dyn != '0);
  c_bad_capture: cover property (CAP_DONE && !commit);
  c_hdmi_image: cover property (s.hdmi != '0);
endmodule

// *** tb/edid_source.sv ***
`timescale 1ns/1ns
// Video source on one input: reads the image after hot-plug rises
module edid_source #(
  parameter int GAP = 0 // Extra wait cycles per byte
) (
  input  wire logic             clock,    // System clock
  input  wire logic             reset,    // Synchronous, active high
  input  wire logic             hpd,      // Hot-plug from the router
  input  wire logic [7:0]       rd_data,  // Byte read back
  output logic      [7:0]       rd_addr,  // Byte address asked for
  output logic      [255:0][7:0] rd_img,  // Last image read
  output logic                  video_on, // Source would send video
  output logic      [7:0]       rd_cnt    // Completed reads
);
  logic       hpd_q;
  logic       reading;
  logic [8:0] idx;
  int         ph;
  logic [7:0] sum;

  // Slow byte-by-byte read, address held until its data is taken
  always @(posedge clock) begin
    hpd_q <= hpd;
    if (reset) begin
      reading  <= 1'b0;
      video_on <= 1'b0;
      rd_cnt   <= 8'h00;
      rd_addr  <= 8'h00;
    end else if (!hpd) begin
      reading  <= 1'b0;
      video_on <= 1'b0;
      rd_addr  <= rd_addr + 8'h5B; // Idle address keeps moving
    end else if (!hpd_q) begin
      reading <= 1'b1;
      idx     <= 9'h000;
      ph      <= 0;
      sum     <= 8'h00;
      rd_addr <= 8'h00;
    end else if (reading) begin
      if (ph == 3 + GAP) begin
        rd_img[idx[7:0]] <= rd_data;
        if (idx < 9'h080) sum <= sum + rd_data;
        ph <= 0;
        if (idx == 9'h0FF) begin
          reading  <= 1'b0;
          video_on <= (sum === 8'h00);
          rd_cnt   <= rd_cnt + 8'h01;
        end else begin
          idx     <= idx + 9'h001;
          rd_addr <= idx[7:0] + 8'h01;
        end
      end else begin
        ph <= ph + 1;
      end
    end else begin
      rd_addr <= rd_addr + 8'h5B;
    end
  end
endmodule

// *** tb/edid_router_tb.sv ***
`timescale 1ns/1ns
module edid_router_tb;
  localparam int HOLD = 20;
  logic                    clock = 1'b0;
  logic                    reset = 1'b1;
  logic                    lib_wr = 1'b0, unlock = 1'b0;
  logic [2:0]              lib_slot = 3'h0, sel_slot = 3'h0;
  logic [7:0]              lib_addr = 8'h00, lib_data = 8'h00;
  logic                    cap_wr = 1'b0, cap_done = 1'b0;
  logic [0:0]              cap_port = 1'h0, sel_out = 1'h0;
  logic [7:0]              cap_addr = 8'h00, cap_data = 8'h00;
  logic                    sel_go = 1'b0, sel_dyn = 1'b0;
  logic [1:0]              sel_in = 2'h0;
  logic [3:0][7:0]         src_addr, src_data, rd_cnt;
  logic [3:0][255:0][7:0]  seen;
  logic [3:0]              hpd, hdmi_cap, vid_on;
  logic [1:0]              cap_valid;
  logic                    busy;
  logic [7:0]              img [256];
  int                      fail_count = 0, n_tests = 0;

  always #2 clock = ~clock;

  edid_router #(.HPD_HOLD_CYCLES(HOLD)) dut (
    .CLOCK(clock), .RESET(reset), .LIB_WR(lib_wr), .LIB_SLOT(lib_slot),
    .LIB_ADDR(lib_addr), .LIB_DATA(lib_data), .FACTORY_UNLOCK(unlock),
    .CAP_WR(cap_wr), .CAP_PORT(cap_port), .CAP_ADDR(cap_addr),
    .CAP_DATA(cap_data), .CAP_DONE(cap_done), .SEL_GO(sel_go),
    .SEL_IN(sel_in), .SEL_DYNAMIC(sel_dyn), .SEL_SLOT(sel_slot),
    .SEL_OUT(sel_out), .SRC_ADDR(src_addr), .SRC_DATA(src_data),
    .HPD(hpd), .HDMI_CAP(hdmi_cap), .CAP_VALID(cap_valid), .BUSY(busy));

  // One source per input, two of them slow readers
  for (genvar g = 0; g < 4; g++) begin : g_src
    edid_source #(.GAP(g % 2)) u_src (
      .clock(clock), .reset(reset), .hpd(hpd[g]), .rd_data(src_data[g]),
      .rd_addr(src_addr[g]), .rd_img(seen[g]), .video_on(vid_on[g]),
      .rd_cnt(rd_cnt[g]));
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Image with zero base checksum, optional vendor marker in block 1
  task automatic make(input logic [7:0] seed, input logic [7:0] ext,
                      input logic oui);
    logic [7:0] s;
    s = 8'h00;
    for (int a = 0; a < 256; a++) img[a] = seed * 8'h03 + a[7:0];
    img[126] = ext;
    for (int a = 0; a < 127; a++) s = s + img[a];
    img[127] = 8'h00 - s;
    if (oui) {img[8'h84], img[8'h85], img[8'h86]} = 24'h030C00;
  endtask

  task automatic lib_load(input logic [2:0] slot);
    for (int a = 0; a < 256; a++) begin
      @(negedge clock);
      {lib_wr, lib_slot, lib_addr, lib_data} = {1'b1, slot, a[7:0], img[a]};
    end
    @(negedge clock);
    lib_wr = 1'b0;
  endtask

  task automatic cap_load(input logic [0:0] port);
    for (int a = 0; a < 128; a++) begin
      @(negedge clock);
      {cap_wr, cap_port, cap_addr, cap_data} = {1'b1, port, a[7:0], img[a]};
    end
    @(negedge clock);
    {cap_wr, cap_done} = 2'b01;
    @(negedge clock);
    cap_done = 1'b0;
    @(negedge clock);
  endtask

  task automatic sel(input int in, input logic dyn, input int slot,
                     input int out);
    @(negedge clock);
    {sel_in, sel_dyn, sel_slot, sel_out} = {in[1:0], dyn, slot[2:0], out[0]};
    sel_go = 1'b1;
    @(negedge clock);
    sel_go = 1'b0;
  endtask

  // Hot-plug of this input must stay high for a while
  task automatic no_change(input int in);
    logic bad;
    bad = 1'b0;
    repeat (400) begin
      @(negedge clock);
      if (hpd[in] !== 1'b1) bad = 1'b1;
    end
    check(bad, 0);
  endtask

  // Wait for one image change on an input and judge the source's read
  task automatic expect_change(input int in, input logic hdmi, input int n);
    logic [7:0] c0;
    logic       h0;
    int         k;
    c0 = rd_cnt[in];
    h0 = hdmi_cap[in];
    k = 0;
    while (busy !== 1'b1 && k < 100) begin @(negedge clock); k++; end
    check(busy, 1);
    check(hdmi_cap[in], h0);
    k = 0;
    while (hpd[in] !== 1'b0 && k < 2000) begin @(negedge clock); k++; end
    check(hpd, 4'hF & ~(4'h1 << in));
    k = 0;
    while (hpd[in] === 1'b0 && k < 1000) begin @(negedge clock); k++; end
    check(k, HOLD);
    k = 0;
    while (rd_cnt[in] === c0 && k < 3000) begin @(negedge clock); k++; end
    check(rd_cnt[in], c0 + 8'h01);
    check(vid_on[in], 1);
    check(hdmi_cap[in], hdmi);
    for (int b = 0; b < n; b++) check(seen[in][b], img[b]);
  endtask

  task automatic s_reset();
    check({hpd, hdmi_cap, cap_valid, busy}, 11'h780);
    check(src_data, 32'h00000000);
  endtask

  // Two requests queued behind a running copy, neither may be lost
  task automatic s_both();
    logic [3:0][7:0] c;
    c = rd_cnt;
    sel(3, 1'b0, 6, 0);
    sel(2, 1'b0, 6, 0);
    sel(1, 1'b0, 6, 0);
    repeat (2600) @(negedge clock);
    for (int i = 1; i < 4; i++) check(rd_cnt[i], c[i] + 8'h01);
    check(hpd, 4'hF);
    check(vid_on[3:1], 3'h7);
    check(seen[1][200], img[200]);
    check(seen[3][255], img[255]);
  endtask

  task automatic s_static();
    make(8'h01, 8'h00, 1'b0);
    lib_load(3'h4);
    sel(1, 1'b0, 4, 0);
    expect_change(1, 1'b0, 256);
  endtask

  // Preset slot: unlocked load, then a locked write that must be lost
  task automatic s_factory();
    make(8'h02, 8'h01, 1'b1);
    unlock = 1'b1;
    lib_load(3'h0);
    unlock = 1'b0;
    @(negedge clock);
    {lib_wr, lib_slot, lib_addr, lib_data} = {1'b1, 3'h0, 8'h05, ~img[5]};
    @(negedge clock);
    lib_wr = 1'b0;
    sel(2, 1'b0, 0, 0);
    expect_change(2, 1'b1, 256);
    make(8'h07, 8'h01, 1'b0);
    lib_load(3'h6);
    sel(2, 1'b0, 6, 0);
    expect_change(2, 1'b0, 256);
  endtask

  task automatic s_dynamic();
    sel(3, 1'b1, 0, 1);
    no_change(3);
    make(8'h03, 8'h00, 1'b0);
    cap_load(1'h1);
    check(cap_valid, 2'h2);
    expect_change(3, 1'b0, 128);
    make(8'h04, 8'h00, 1'b0);
    cap_load(1'h1);
    expect_change(3, 1'b0, 128);
    make(8'h05, 8'h00, 1'b0);
    img[127] = img[127] ^ 8'h01;
    cap_load(1'h1);
    no_change(3);
    check(cap_valid, 2'h2);
    make(8'h04, 8'h00, 1'b0);
    sel(0, 1'b1, 0, 1);
    expect_change(0, 1'b0, 128);
  endtask

  initial begin
    repeat (4) @(negedge clock);
    reset = 1'b0;
    s_reset();
    s_static();
    s_factory();
    s_both();
    s_dynamic();
    summarize();
  end

  // Watchdog well past the expected run time
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule
